// ---- src/wdt_pkg.sv ----
package wdt_pkg;

	// ****************************************************************
	// Register map (byte addresses on the APB bus)
	// ****************************************************************
	localparam int          ADDR_WIDTH      = 8;
	localparam int          DATA_WIDTH      = 32;
	localparam logic [7:0]  ADDR_CONTROL    = 8'h00;
	localparam logic [7:0]  ADDR_STATE      = 8'h04;
	localparam logic [7:0]  ADDR_COUNT      = 8'h08;
	localparam logic [7:0]  ADDR_IRQ_STATUS = 8'h0c;
	localparam logic [7:0]  ADDR_IRQ_CLEAR  = 8'h10;
	localparam logic [7:0]  ADDR_IRQ_ENABLE = 8'h14;

	// ****************************************************************
	// Control register fields
	// ****************************************************************
	localparam int          SOFT_EN_BIT     = 0;
	localparam int          PS_LSB          = 1;
	localparam int          PS_MSB          = 5;
	localparam int          PS_WIDTH        = 5;
	localparam logic [4:0]  PS_RESET        = 5'h0b;
	localparam logic [4:0]  PS_MAX          = 5'h12;
	localparam logic [4:0]  PS_BASE_EXP     = 5'h05;
	localparam logic        SOFT_EN_RESET   = 1'h0;

	// ****************************************************************
	// State register fields
	// ****************************************************************
	localparam int          ST_EXPIRY_N     = 0;
	localparam int          ST_SLEEP_N      = 1;
	localparam int          ST_ACTIVE       = 2;
	localparam int          ST_ASLEEP       = 3;

	// ****************************************************************
	// Interrupt events
	// ****************************************************************
	localparam int          EVT_RESET       = 0;
	localparam int          EVT_WAKE        = 1;
	localparam int          EVT_COUNT       = 2;

	// ****************************************************************
	// Configuration mode field encodings
	// ****************************************************************
	localparam logic [1:0]  MODE_OFF        = 2'h0;
	localparam logic [1:0]  MODE_SOFT       = 2'h1;
	localparam logic [1:0]  MODE_NO_SLEEP   = 2'h2;
	localparam logic [1:0]  MODE_ON         = 2'h3;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int          CLK_HZ          = 10_000_000;
	localparam int          OSC_HZ          = 31_000;
	localparam int          MIN_SAMPLES     = 4;
	localparam int          COUNT_WIDTH     = 23;

endpackage : wdt_pkg

// ---- src/lf_tick_sync.sv ----
`timescale 1ns/1ps

module lf_tick_sync
	import wdt_pkg::*;
(
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_reset,
	// Oscillator level from outside the clock domain
	input  wire logic i_low_freq_oscillator,
	// One-cycle pulse per oscillator rising edge
	output logic      o_tick
);

	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
		logic tick;
	} sync_state_t;

	sync_state_t s_r;
	sync_state_t s_nxt;

	// ****************************************************************
	// Two-flop synchroniser and edge detect
	// ****************************************************************
	always_comb begin
		s_nxt       = s_r;
		s_nxt.sync1 = i_low_freq_oscillator;
		s_nxt.sync2 = s_r.sync1;
		s_nxt.prev  = s_r.sync2;
		s_nxt.tick  = s_r.sync2 & ~s_r.prev;
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_tick = s_r.tick;

endmodule // lf_tick_sync

// ---- src/watchdog_timer.sv ----
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps

// Operation
// - The period is selectable from a nominal 1 ms to 256 s and is two seconds after any reset.
// - Period field value n from 00000 to 10010 selects a prescale of 2^(n+5) oscillator ticks.
// - Period field values 10011 to 11111 fall back to the shortest 1:32 prescale.
// - Reset loads the period field with 01011, a 1:65536 prescale.
// - The count is cleared by reset, clear instruction, sleep entry, interrupt wake, oscillator fail, disable and start-up timer.
// - Sleep entry clears the count, which then keeps counting in sleep if the watchdog is enabled there.
// - Sleep exit clears the count again and holds it while the start-up timer runs.
// - A time-out in sleep wakes the device instead of resetting it and clears the expiry flag; the sleep flag keeps the low set at sleep entry.
// - Mode 00, or mode 01 with the soft enable low, holds the watchdog cleared and disabled.
// - Clock source switches and divider changes leave the count alone.
// - The soft enable bit matters only in mode 01, where 1 turns the watchdog on.
// - Control holds the period field in bits 5..1, the soft enable in bit 0, and reads zero in bits 7..6.
// - All intervals are counted in ticks of the dedicated low-frequency oscillator.
// - Mode 11 keeps the watchdog active at all times, sleep included.
// - Mode 10 keeps the watchdog active while awake and off in sleep.
// - A time-out while awake raises a system reset.

module watchdog_timer
	import wdt_pkg::*;
#(
	parameter int CLOCK_HZ   = CLK_HZ,
	parameter int OSC_RATE   = OSC_HZ,
	parameter int CNT_WIDTH  = COUNT_WIDTH
)(
	// Clock and reset
	input  wire logic                  i_clk,
	input  wire logic                  i_reset,
	// APB slave
	input  wire logic                  i_psel,
	input  wire logic                  i_penable,
	input  wire logic                  i_pwrite,
	input  wire logic [ADDR_WIDTH-1:0] i_paddr,
	input  wire logic [DATA_WIDTH-1:0] i_pwdata,
	output logic      [DATA_WIDTH-1:0] o_prdata,
	output logic                       o_pready,
	output logic                       o_pslverr,
	// Oscillator
	input  wire logic                  i_low_freq_oscillator,
	// Core side
	input  wire logic                  i_clear_instruction,
	input  wire logic                  i_sleep,
	input  wire logic                  i_wake_interrupt,
	input  wire logic                  i_osc_fail,
	input  wire logic                  i_startup_timer_running,
	input  wire logic [1:0]            i_config_mode_field,
	// Results
	output logic                       o_system_reset,
	output logic                       o_wake,
	output logic                       o_expiry_flag_n,
	output logic                       o_sleep_flag_n,
	output logic                       o_irq
);

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	// The oscillator is sampled, so the bus clock must be several times faster.
	if (CLOCK_HZ < MIN_SAMPLES * OSC_RATE) begin : g_rate_check
		$error("Bus clock too slow to sample the oscillator.");
	end
	if (CNT_WIDTH < COUNT_WIDTH) begin : g_width_check
		$error("Counter too narrow for the longest period.");
	end

	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [PS_WIDTH-1:0]   period_select;
		logic                  soft_enable;
		logic [CNT_WIDTH-1:0]  count;
		logic                  sleep_seen;
		logic                  expiry_flag_n;
		logic                  sleep_flag_n;
		logic                  system_reset;
		logic                  wake;
		logic [EVT_COUNT-1:0]  irq_status;
		logic [EVT_COUNT-1:0]  irq_enable;
		logic                  irq;
		logic                  pready;
		logic                  pslverr;
		logic [DATA_WIDTH-1:0] prdata;
	} wdt_state_t;

	localparam wdt_state_t RESET_STATE = '{
		period_select: PS_RESET,
		soft_enable:   SOFT_EN_RESET,
		count:         '0,
		sleep_seen:    1'b0,
		expiry_flag_n: 1'b1,
		sleep_flag_n:  1'b1,
		system_reset:  1'b0,
		wake:          1'b0,
		irq_status:    '0,
		irq_enable:    '0,
		irq:           1'b0,
		pready:        1'b0,
		pslverr:       1'b0,
		prdata:        '0
	};

	wdt_state_t s_r;
	wdt_state_t s_nxt;

	logic tick;

	// ****************************************************************
	// Oscillator tick
	// ****************************************************************
	// dedicated oscillator ticks
	lf_tick_sync u_tick (
		.i_clk                 (i_clk),
		.i_reset               (i_reset),
		.i_low_freq_oscillator (i_low_freq_oscillator),
		.o_tick                (tick)
	);

	// ****************************************************************
	// Period decode
	// ****************************************************************
	function automatic logic [CNT_WIDTH-1:0] terminal_count(input logic [PS_WIDTH-1:0] ps);
		logic [PS_WIDTH-1:0] expo;
		logic [CNT_WIDTH:0]  span;
		expo = (ps > PS_MAX) ? PS_BASE_EXP : PS_WIDTH'(ps + PS_BASE_EXP);
		span = (CNT_WIDTH+1)'(1) << expo;
		span = span - (CNT_WIDTH+1)'(1);
		return span[CNT_WIDTH-1:0];
	endfunction

	// ****************************************************************
	// Enable and clear decisions
	// ****************************************************************
	logic active;
	logic sleep_entry;
	logic sleep_exit;
	logic hold_clear;
	logic expire;

	always_comb begin
		unique case (i_config_mode_field)
			MODE_ON:       active = 1'b1;
			MODE_NO_SLEEP: active = ~i_sleep;
			MODE_SOFT:     active = s_r.soft_enable;
			MODE_OFF:      active = 1'b0;
		endcase
	end

	assign sleep_entry = i_sleep & ~s_r.sleep_seen;
	assign sleep_exit  = ~i_sleep & s_r.sleep_seen;

	// clear on exit, hold during start-up
	assign hold_clear = i_clear_instruction | sleep_entry | sleep_exit | i_wake_interrupt |
	                    i_osc_fail | ~active | i_startup_timer_running;

	assign expire = ~hold_clear & tick & (s_r.count == terminal_count(s_r.period_select));

	// ****************************************************************
	// APB decode
	// ****************************************************************
	logic                  setup;
	logic                  access;
	logic                  mapped;
	logic [DATA_WIDTH-1:0] rd_word;
	logic [DATA_WIDTH-1:0] status_word;

	assign setup  = i_psel & ~i_penable;
	assign access = i_psel & i_penable & s_r.pready;

	always_comb begin
		status_word              = '0;
		status_word[ST_EXPIRY_N] = s_r.expiry_flag_n;
		status_word[ST_SLEEP_N]  = s_r.sleep_flag_n;
		status_word[ST_ACTIVE]   = active;
		status_word[ST_ASLEEP]   = i_sleep;
	end

	always_comb begin
		mapped  = 1'b1;
		rd_word = '0;
		unique case (i_paddr)
			ADDR_CONTROL: begin
				rd_word[PS_MSB:PS_LSB] = s_r.period_select;
				rd_word[SOFT_EN_BIT]   = s_r.soft_enable;
			end
			ADDR_STATE: begin
				rd_word = status_word;
			end
			ADDR_COUNT: begin
				rd_word[CNT_WIDTH-1:0] = s_r.count;
			end
			ADDR_IRQ_STATUS: begin
				rd_word[EVT_COUNT-1:0] = s_r.irq_status;
			end
			ADDR_IRQ_ENABLE: begin
				rd_word[EVT_COUNT-1:0] = s_r.irq_enable;
			end
			ADDR_IRQ_CLEAR: begin
				rd_word = '0;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	logic [EVT_COUNT-1:0] evt;
	logic [EVT_COUNT-1:0] clr;

	always_comb begin
		s_nxt = s_r;

		s_nxt.sleep_seen = i_sleep;

		// Counter.
		if (hold_clear || expire) begin
			s_nxt.count = '0;
		end else if (tick) begin
			s_nxt.count = s_r.count + CNT_WIDTH'(1);
		end

		// Status flags follow the core's power-down conventions.
		if (i_clear_instruction) begin
			s_nxt.expiry_flag_n = 1'b1;
			s_nxt.sleep_flag_n  = 1'b1;
		end
		if (sleep_entry) begin
			s_nxt.expiry_flag_n = 1'b1;
			s_nxt.sleep_flag_n  = 1'b0;
		end
		if (expire) begin
			s_nxt.expiry_flag_n = 1'b0;
		end

		s_nxt.system_reset = expire & ~i_sleep;
		s_nxt.wake         = expire & i_sleep;

		// Interrupt events: a new event beats a clear in the same cycle.
		evt            = '0;
		evt[EVT_RESET] = expire & ~i_sleep;
		evt[EVT_WAKE]  = expire & i_sleep;
		clr            = '0;

		// Bus: answer one cycle after setup, so every access is two cycles.
		s_nxt.pready  = setup;
		s_nxt.pslverr = setup & ~mapped;
		s_nxt.prdata  = (setup && !i_pwrite) ? rd_word : '0;

		if (access && i_pwrite && !s_r.pslverr) begin
			unique case (i_paddr)
				ADDR_CONTROL: begin
					s_nxt.period_select = i_pwdata[PS_MSB:PS_LSB];
					s_nxt.soft_enable   = i_pwdata[SOFT_EN_BIT];
				end
				ADDR_IRQ_CLEAR: begin
					clr = i_pwdata[EVT_COUNT-1:0];
				end
				ADDR_IRQ_ENABLE: begin
					s_nxt.irq_enable = i_pwdata[EVT_COUNT-1:0];
				end
				default: begin
				end
			endcase
		end

		s_nxt.irq_status = (s_r.irq_status & ~clr) | evt;
		s_nxt.irq        = |(s_nxt.irq_status & s_nxt.irq_enable);
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	// defaults restored by reset
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			s_r <= RESET_STATE;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign o_prdata        = s_r.prdata;
	assign o_pready        = s_r.pready;
	assign o_pslverr       = s_r.pslverr;
	assign o_system_reset  = s_r.system_reset;
	assign o_wake          = s_r.wake;
	assign o_expiry_flag_n = s_r.expiry_flag_n;
	assign o_sleep_flag_n  = s_r.sleep_flag_n;
	assign o_irq           = s_r.irq;

endmodule // watchdog_timer

// ---- test/lf_osc_model.sv ----
`timescale 1ns/1ps

// ****************************************************************
// Low-frequency oscillator model
// ****************************************************************
module lf_osc_model #(
	parameter int HALF_NS = 415
)(
	// Free-running output
	output logic o_osc
);
	// It runs free, unrelated to the bus clock, so ticks land at any phase of it.
	initial o_osc = 1'h0;
	always #(HALF_NS) o_osc = ~o_osc;
endmodule // lf_osc_model

// ---- test/wdt_props.sv ----
`timescale 1ns/1ps

module wdt_props
	import wdt_pkg::*;
(
	// Clock and reset
	input wire logic       i_clk,
	input wire logic       i_reset,
	// Core side
	input wire logic       i_clear_instruction,
	input wire logic       i_sleep,
	input wire logic       i_wake_interrupt,
	input wire logic       i_osc_fail,
	input wire logic       i_startup_timer_running,
	input wire logic [1:0] i_config_mode_field,
	// Results
	input wire logic       o_system_reset,
	input wire logic       o_wake,
	input wire logic       o_expiry_flag_n,
	input wire logic       o_sleep_flag_n
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_reset);

	a_sleep_flag_low:
		assert property ($rose(i_sleep) |=> !o_sleep_flag_n)
		else $error("sleep flag not low after sleep entry");
	a_wake_in_sleep:
		assert property (o_wake |-> $past(i_sleep))
		else $error("wake while awake");
	a_reset_awake:
		assert property (o_system_reset |-> !$past(i_sleep))
		else $error("system reset from sleep");
	a_expiry_cause:
		assert property ($fell(o_expiry_flag_n) |-> o_system_reset || o_wake)
		else $error("expiry flag fell without time-out");
	a_off_silent:
		assert property ((i_config_mode_field == MODE_OFF) [*2] |-> !o_system_reset && !o_wake)
		else $error("time-out while off");
	a_clear_quiet:
		assert property (i_clear_instruction |=> o_expiry_flag_n && o_sleep_flag_n && !o_system_reset && !o_wake)
		else $error("clear did not clear");
	a_hold_quiet:
		assert property ((i_osc_fail || i_startup_timer_running || i_wake_interrupt) [*2] |->
			!o_system_reset && !o_wake)
		else $error("time-out while held");
	a_nosleep_off:
		assert property ((i_sleep && i_config_mode_field == MODE_NO_SLEEP) [*2] |-> !o_wake)
		else $error("wake in mode without sleep watch");
endmodule // wdt_props

bind watchdog_timer wdt_props chk (.i_clk, .i_reset, .i_clear_instruction, .i_sleep, .i_wake_interrupt,
	.i_osc_fail, .i_startup_timer_running, .i_config_mode_field, .o_system_reset, .o_wake, .o_expiry_flag_n,
	.o_sleep_flag_n);

// ---- test/watchdog_timer_tb_top.sv ----
`timescale 1ns/1ps

module watchdog_timer_tb_top
	import wdt_pkg::*;
;
	logic                  i_clk, i_reset, i_psel, i_penable, i_pwrite, i_clear_instruction, i_sleep;
	logic                  i_wake_interrupt, i_osc_fail, i_startup_timer_running;
	logic [ADDR_WIDTH-1:0] i_paddr;
	logic [DATA_WIDTH-1:0] i_pwdata, o_prdata, wdat;
	logic [1:0]            i_config_mode_field;
	logic                  o_pready, o_pslverr, o_system_reset, o_wake, o_expiry_flag_n, o_sleep_flag_n, o_irq;
	wire                   i_low_freq_oscillator;
	logic [DATA_WIDTH:0]   expq[$];
	logic [4:0]            ps_tab[4] = '{5'h00, 5'h01, 5'h13, 5'h1f};
	int                    tk_tab[4] = '{32, 64, 32, 32};
	int                    bad_count, num_checks, cyc, seed;

	lf_osc_model osc (.o_osc(i_low_freq_oscillator));
	watchdog_timer dut (.i_clk, .i_reset, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
		.o_pready, .o_pslverr, .i_low_freq_oscillator, .i_clear_instruction, .i_sleep, .i_wake_interrupt,
		.i_osc_fail, .i_startup_timer_running, .i_config_mode_field, .o_system_reset, .o_wake,
		.o_expiry_flag_n, .o_sleep_flag_n, .o_irq);

	always #50 i_clk = ~i_clk;

	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			end_sim();
		end
	end

	// Every bus answer is paired with the oldest expectation noted by the driver.
	always @(negedge i_clk) begin
		if (o_pready === 1'h1)
			chk({o_pslverr, o_prdata}, expq.pop_front());
	end

	task automatic chk(input logic [32:0] seen, input logic [32:0] want);
		num_checks++;
		if (seen !== want) begin
			bad_count++;
			$display("BAD %0t seen %h want %h", $time, seen, want);
		end
	endtask

	// Only the bench's cycle ceiling ends a wait for the bus answer.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] want);
		expq.push_back(want);
		i_psel <= 1'h1;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'h1;
		do
			@(negedge i_clk);
		while (o_pready !== 1'h1);
		@(posedge i_clk);
		i_psel <= 1'h0;
		i_penable <= 1'h0;
		@(posedge i_clk);
	endtask

	task automatic clear();
		i_clear_instruction <= 1'h1;
		@(posedge i_clk);
		i_clear_instruction <= 1'h0;
	endtask

	// The window allows one oscillator period of phase slack plus the synchroniser delay.
	task automatic expire(input int t, input logic slept);
		int n;
		n = 0;
		do begin
			@(negedge i_clk);
			n++;
		end while (!(o_system_reset || o_wake) && n < 10000);
		chk(33'(n >= (t - 1) * 83 / 10 && n <= t * 83 / 10 + 8), 33'h1);
		chk(33'({o_system_reset, o_wake, o_expiry_flag_n, o_sleep_flag_n}), 33'({slept ? 2'h1 : 2'h2, 1'h0, !slept}));
		@(posedge i_clk);
	endtask

	task automatic quiet(input int n);
		logic hit;
		hit = 1'h0;
		repeat (n) begin
			@(negedge i_clk);
			hit |= o_system_reset | o_wake;
		end
		@(posedge i_clk);
		chk(33'(hit), 33'h0);
	endtask

	task automatic chk_irq(input logic want);
		@(negedge i_clk);
		chk(33'(o_irq), 33'(want));
		@(posedge i_clk);
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ****************************************************************
	// Stimulus
	// ****************************************************************
	initial begin
		seed = 32'h3bf22949;
		i_clk = 1'h0;
		i_reset = 1'h1;
		{i_psel, i_penable, i_pwrite, i_clear_instruction, i_sleep} = 5'h0;
		{i_wake_interrupt, i_osc_fail, i_startup_timer_running} = 3'h0;
		i_paddr = 8'h0;
		i_pwdata = 32'h0;
		i_config_mode_field = MODE_ON;
		repeat (20) @(posedge i_clk);
		i_reset <= 1'h0;
		@(posedge i_clk);
		apb(1'h0, ADDR_CONTROL, 32'h0, {27'h0, PS_RESET, SOFT_EN_RESET});
		apb(1'h0, 8'h18, 32'h0, {1'h1, 32'h0});
		wdat = $random(seed);
		apb(1'h1, ADDR_CONTROL, wdat, 33'h0);
		apb(1'h0, ADDR_CONTROL, 32'h0, {1'h0, wdat & 32'h3f});
		apb(1'h1, ADDR_IRQ_ENABLE, 32'h1, 33'h0);
		for (int i = 0; i < 4; i++) begin
			apb(1'h1, ADDR_CONTROL, {26'h0, ps_tab[i], 1'h0}, 33'h0);
			clear();
			expire(tk_tab[i], 1'h0);
		end
		chk_irq(1'h1);
		apb(1'h0, ADDR_IRQ_STATUS, 32'h0, 33'h1);
		apb(1'h1, ADDR_IRQ_ENABLE, 32'h0, 33'h0);
		chk_irq(1'h0);
		apb(1'h1, ADDR_IRQ_CLEAR, 32'h3, 33'h0);
		apb(1'h0, ADDR_IRQ_STATUS, 32'h0, 33'h0);
		i_config_mode_field <= MODE_OFF;
		apb(1'h1, ADDR_CONTROL, 32'h1, 33'h0);
		quiet(600);
		i_config_mode_field <= MODE_SOFT;
		apb(1'h1, ADDR_CONTROL, 32'h0, 33'h0);
		quiet(600);
		apb(1'h1, ADDR_CONTROL, 32'h1, 33'h0);
		expire(32, 1'h0);
		i_config_mode_field <= MODE_NO_SLEEP;
		apb(1'h1, ADDR_CONTROL, 32'h0, 33'h0);
		clear();
		expire(32, 1'h0);
		i_sleep <= 1'h1;
		quiet(600);
		i_sleep <= 1'h0;
		i_config_mode_field <= MODE_ON;
		clear();
		repeat (170) @(posedge i_clk);
		i_sleep <= 1'h1;
		expire(32, 1'h1);
		apb(1'h0, ADDR_IRQ_STATUS, 32'h0, 33'h3);
		i_sleep <= 1'h0;
		for (int k = 0; k < 3; k++) begin
			{i_startup_timer_running, i_osc_fail, i_wake_interrupt} <= 3'h1 << k;
			quiet(400);
			apb(1'h0, ADDR_COUNT, 32'h0, 33'h0);
		end
		end_sim();
	end
endmodule // watchdog_timer_tb_top
